// ### src/map_guard_pkg.sv
// Constants and carrier types shared by the map guard, map store and checksum files.
package map_guard_pkg;
	localparam int ADDR_W = 8;
	localparam int MAP_WORDS = 31;
	localparam int WORD_W = 24;
	localparam int PAIR_COUNT = (MAP_WORDS + 1) / 2;
	localparam logic [5:0] GUARD_IDX = 6'h1f;
	localparam logic [5:0] STATUS_IDX = 6'h20;
	localparam logic [5:0] MASK_IDX = 6'h21;
	localparam int KEY_LSB = 16;
	localparam int KEY_W = 8;
	localparam int SUM_LSB = 0;
	localparam int SUM_W = 16;
	localparam logic [KEY_W-1:0] KEY_OPEN = 8'ha5;
	localparam logic [SUM_W-1:0] SUM_RESET = 16'h0000;
	localparam logic [SUM_W-1:0] CRC_POLY = 16'h1021;
	localparam logic [SUM_W-1:0] CRC_INIT = 16'hffff;
	localparam logic [WORD_W-1:0] HIDDEN_VALUE = 24'h000000;
	localparam int EV_W = 2;
	localparam int EV_SUM = 0;
	localparam int EV_REFUSED = 1;
	localparam logic [EV_W-1:0] STATUS_RESET = 2'h0;
	localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
	// Checksum period in digital master clock periods; that clock is clk here.
	localparam int SUM_PERIOD = 25;
	localparam int CLK_PER_MASTER = 1;
	localparam int SUM_PERIOD_CYCLES = SUM_PERIOD * CLK_PER_MASTER;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [WORD_W-1:0] data;
		logic [WORD_W-1:0] keep;
	} map_wr_t;

	typedef struct packed {
		logic [WORD_W-1:0] hi;
		logic [WORD_W-1:0] lo;
	} word_pair_t;
endpackage

// ### src/map_store.sv
// Storage for the writable configuration words, with a bus read port and a pair scan port.
`timescale 1ns/1ps
`default_nettype none

module map_store
	import map_guard_pkg::*;
#(
	parameter int WORDS = MAP_WORDS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Write port with per-bit keep mask.
	input wire map_wr_t wr,
	// Bus read port, data one cycle later.
	input wire logic [4:0] rd_idx,
	output logic [WORD_W-1:0] rd_data,
	// Scan port, two neighbouring words one cycle later.
	input wire logic [3:0] pair_idx,
	output var word_pair_t pair_data
);
	typedef struct packed {
		logic [WORDS-1:0][WORD_W-1:0] mem;
		logic [WORD_W-1:0] rd;
		word_pair_t pair;
	} store_t;

	store_t s_reg, s_next;

	// Words past the end read as zero.
	function automatic logic [WORD_W-1:0] fetch(input store_t s, input int i);
		logic [WORD_W-1:0] v;
		v = '0;
		if (i < WORDS) begin
			v = s.mem[i];
		end
		return v;
	endfunction

	always_comb begin
		s_next = s_reg;
		if (wr.en && int'(wr.idx) < WORDS) begin
			s_next.mem[wr.idx] = (s_reg.mem[wr.idx] & ~wr.keep) | (wr.data & wr.keep);
		end
		s_next.rd = fetch(s_reg, int'(rd_idx));
		s_next.pair.lo = fetch(s_reg, 2 * int'(pair_idx));
		s_next.pair.hi = fetch(s_reg, 2 * int'(pair_idx) + 1);
		if (!rst_b) begin
			s_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign rd_data = s_reg.rd;
	assign pair_data = s_reg.pair;
endmodule
`default_nettype wire

// ### src/map_crc.sv
// CRC-16 engine that walks the configuration words two at a time.
`timescale 1ns/1ps
`default_nettype none

module map_crc
	import map_guard_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Control.
	input wire logic start,
	input wire logic abort,
	// Scan port towards the store.
	output logic [3:0] pair_idx,
	input wire word_pair_t pair_data,
	// Result.
	output logic done,
	output logic [SUM_W-1:0] sum
);
	typedef struct packed {
		logic busy;
		logic [4:0] idx;
		logic feed;
		logic [3:0] feed_idx;
		logic [SUM_W-1:0] acc;
		logic done;
		logic [SUM_W-1:0] sum;
	} crc_state_t;

	crc_state_t s_reg, s_next;

	// Word enters most significant bit first.
	function automatic logic [SUM_W-1:0] crc_word(input logic [SUM_W-1:0] c,
			input logic [WORD_W-1:0] w);
		logic fb;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			fb = c[SUM_W-1] ^ w[i];
			c = {c[SUM_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
		end
		return c;
	endfunction

	always_comb begin
		logic [SUM_W-1:0] a;
		a = s_reg.acc;
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.feed = s_reg.busy;
		s_next.feed_idx = s_reg.idx[3:0];
		if (s_reg.busy) begin
			s_next.idx = s_reg.idx + 5'd1;
			if (s_reg.idx == 5'(PAIR_COUNT - 1)) begin
				s_next.busy = 1'b0;
			end
		end
		if (s_reg.feed) begin
			a = crc_word(a, pair_data.lo);
			if (2 * int'(s_reg.feed_idx) + 1 < MAP_WORDS) begin
				a = crc_word(a, pair_data.hi);
			end
			s_next.acc = a;
			if (s_reg.feed_idx == 4'(PAIR_COUNT - 1)) begin
				s_next.done = 1'b1;
				s_next.sum = a;
			end
		end
		if (start) begin
			s_next.busy = 1'b1;
			s_next.idx = '0;
			s_next.feed = 1'b0;
			s_next.acc = CRC_INIT;
		end
		if (abort || !rst_b) begin
			s_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign pair_idx = s_reg.idx[3:0];
	assign done = s_reg.done;
	assign sum = s_reg.sum;
endmodule
`default_nettype wire

// ### src/map_guard.sv
// Map guard key, map checksum and the AXI4-Lite register slave around them.
// What this block does
// - Guard register holds the key in bits 23:16, checksum in 15:0.
// - Key 0xa5, also the reset value, leaves every map register writable.
// - While open, checksum field and checksum interrupt condition stay cleared.
// - While open, no checksum is computed.
// - While locked, writes to map words 0..30 are refused; guard, status and mask registers stay writable.
// - While locked, reads of map words 0..30 return a filler value; guard, status and mask read normally.
// - While locked, checksum runs continuously; its interrupt needs its enable bit.
// - Checksum is a CRC-16 over the writable map registers.
// - Checksum field is read-only; writes to its bits change nothing.
// - Checksum is recomputed and updated every 25 master clock periods.
// - Checksum field reads 0x0000 whenever the key is 0xa5.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module map_guard
	import map_guard_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Write address channel.
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// Write data channel.
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel.
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel.
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// Read data channel.
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Interrupt.
	output logic irq
);
	typedef struct packed {
		logic [KEY_W-1:0] key;
		logic [SUM_W-1:0] sum;
		logic sum_ok;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [4:0] timer;
		logic [4:0] lock_run;
		logic aw_ok;
		logic [5:0] aw_idx;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_pend;
		logic [5:0] ar_idx;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} guard_state_t;

	guard_state_t s_reg, s_next;
	map_wr_t map_wr;
	logic [WORD_W-1:0] map_rdata;
	logic [3:0] pair_idx;
	word_pair_t pair_data;
	logic scan_start;
	logic scan_abort;
	logic scan_done;
	logic [SUM_W-1:0] scan_sum;
	logic locked;
	logic do_write;
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic [WORD_W-1:0] keep;

	function automatic logic is_mapped(input logic [5:0] idx);
		return (idx < 6'(MAP_WORDS)) || idx == GUARD_IDX || idx == STATUS_IDX ||
			idx == MASK_IDX;
	endfunction

	function automatic logic [WORD_W-1:0] lane_keep(input logic [3:0] strb);
		return {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	map_store #(
		.WORDS(MAP_WORDS)
	) store (
		.clk(clk),
		.rst_b(rst_b),
		.wr(map_wr),
		.rd_idx(araddr[6:2]),
		.rd_data(map_rdata),
		.pair_idx(pair_idx),
		.pair_data(pair_data)
	);

	map_crc crc (
		.clk(clk),
		.rst_b(rst_b),
		.start(scan_start),
		.abort(scan_abort),
		.pair_idx(pair_idx),
		.pair_data(pair_data),
		.done(scan_done),
		.sum(scan_sum)
	);

	assign locked = s_reg.key != KEY_OPEN;
	assign do_write = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
	assign keep = lane_keep(s_reg.wstrb);

	always_comb begin
		s_next = s_reg;
		map_wr = '0;
		ev_set = '0;
		ev_clr = '0;
		scan_start = 1'b0;
		scan_abort = !locked;

		// Address and data are taken independently, one of each at a time.
		if (awvalid && awready) begin
			s_next.aw_ok = 1'b1;
			s_next.aw_idx = awaddr[7:2];
		end
		if (wvalid && wready) begin
			s_next.w_ok = 1'b1;
			s_next.wdata = wdata;
			s_next.wstrb = wstrb;
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end
		if (do_write) begin
			s_next.aw_ok = 1'b0;
			s_next.w_ok = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			if (!is_mapped(s_reg.aw_idx)) begin
				s_next.bresp = RESP_DECERR;
			end else if (s_reg.aw_idx == GUARD_IDX) begin
				// Only the key lanes land; the checksum lanes are dropped.
				s_next.key = (s_reg.key & ~keep[KEY_LSB+:KEY_W]) |
					(s_reg.wdata[KEY_LSB+:KEY_W] & keep[KEY_LSB+:KEY_W]);
			end else if (s_reg.aw_idx == STATUS_IDX) begin
				ev_clr = s_reg.wdata[EV_W-1:0] & keep[EV_W-1:0];
			end else if (s_reg.aw_idx == MASK_IDX) begin
				s_next.mask = (s_reg.mask & ~keep[EV_W-1:0]) |
					(s_reg.wdata[EV_W-1:0] & keep[EV_W-1:0]);
			end else if (locked) begin
				s_next.bresp = RESP_SLVERR;
				ev_set[EV_REFUSED] = 1'b1;
			end else begin
				map_wr.en = 1'b1;
				map_wr.idx = s_reg.aw_idx[4:0];
				map_wr.data = s_reg.wdata[WORD_W-1:0];
				map_wr.keep = keep;
			end
		end

		// Read: the store registers the word at the address edge, the answer follows.
		if (arvalid && arready) begin
			s_next.ar_pend = 1'b1;
			s_next.ar_idx = araddr[7:2];
		end
		if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_reg.ar_pend) begin
			s_next.ar_pend = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			s_next.rdata = '0;
			if (!is_mapped(s_reg.ar_idx)) begin
				s_next.rresp = RESP_DECERR;
			end else if (s_reg.ar_idx == GUARD_IDX) begin
				s_next.rdata[KEY_LSB+:KEY_W] = s_reg.key;
				s_next.rdata[SUM_LSB+:SUM_W] = s_reg.sum;
			end else if (s_reg.ar_idx == STATUS_IDX) begin
				s_next.rdata[EV_W-1:0] = s_reg.status;
			end else if (s_reg.ar_idx == MASK_IDX) begin
				s_next.rdata[EV_W-1:0] = s_reg.mask;
			end else if (locked) begin
				s_next.rdata[WORD_W-1:0] = HIDDEN_VALUE;
			end else begin
				s_next.rdata[WORD_W-1:0] = map_rdata;
			end
		end

		// Checksum pacing: a pass starts every period while the map is locked.
		if (!locked) begin
			s_next.timer = '0;
			s_next.sum = SUM_RESET;
			s_next.sum_ok = 1'b0;
			s_next.lock_run = '0;
		end else begin
			scan_start = s_reg.timer == '0;
			if (s_reg.timer == 5'(SUM_PERIOD_CYCLES - 1)) begin
				s_next.timer = '0;
			end else begin
				s_next.timer = s_reg.timer + 5'd1;
			end
			if (s_reg.lock_run != '1) begin
				s_next.lock_run = s_reg.lock_run + 5'd1;
			end
			if (scan_done) begin
				s_next.sum = scan_sum;
				s_next.sum_ok = 1'b1;
				// A changed sum over a frozen map means the map was disturbed.
				if (s_reg.sum_ok && scan_sum != s_reg.sum) begin
					ev_set[EV_SUM] = 1'b1;
				end
			end
		end

		// Sticky flags: a new event wins over a clear in the same cycle.
		s_next.status = (s_reg.status & ~ev_clr) | ev_set;
		if (!locked) begin
			s_next.status[EV_SUM] = 1'b0;
		end

		if (!rst_b) begin
			s_next = '0;
			s_next.key = KEY_OPEN;
			s_next.sum = SUM_RESET;
			s_next.status = STATUS_RESET;
			s_next.mask = MASK_RESET;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign awready = !s_reg.aw_ok && !s_reg.bvalid;
	assign wready = !s_reg.w_ok && !s_reg.bvalid;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign arready = !s_reg.ar_pend && !s_reg.rvalid;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	// The mask bit of the checksum event is its interrupt enable.
	assign irq = |(s_reg.status & s_reg.mask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	guard_read_a: assert property (
		($rose(s_reg.rvalid) && s_reg.ar_idx == GUARD_IDX) |->
			(s_reg.rdata[31:24] == 8'h00 && s_reg.rdata[KEY_LSB+:KEY_W] == $past(s_reg.key)
			&& s_reg.rdata[SUM_LSB+:SUM_W] == $past(s_reg.sum)))
		else $error("guard register read does not show key and checksum");

	open_write_a: assert property (
		(do_write && !locked && s_reg.aw_idx < 6'(MAP_WORDS)) |->
			map_wr.en ##1 (s_reg.bvalid && s_reg.bresp == RESP_OKAY))
		else $error("write to an open map was not stored");

	open_flag_a: assert property (
		!locked |=> !s_reg.status[EV_SUM])
		else $error("checksum flag set while the map is open");

	open_idle_a: assert property (
		!locked |-> (!scan_start ##1 !scan_done))
		else $error("checksum pass ran while the map is open");

	locked_store_a: assert property (
		map_wr.en |-> !locked)
		else $error("map store written while locked");

	locked_refuse_a: assert property (
		(do_write && locked && s_reg.aw_idx < 6'(MAP_WORDS)) |=>
			(s_reg.status[EV_REFUSED] && s_reg.bresp == RESP_SLVERR))
		else $error("locked write not refused");

	hidden_read_a: assert property (
		($rose(s_reg.rvalid) && s_reg.ar_idx < 6'(MAP_WORDS) && $past(locked)) |->
			s_reg.rdata == {8'h00, HIDDEN_VALUE})
		else $error("locked read exposed stored contents");

	lock_start_a: assert property (
		$rose(locked) |-> scan_start)
		else $error("checksum pass did not start on locking");

	irq_enable_a: assert property (
		(s_reg.status[EV_SUM] && s_reg.mask[EV_SUM]) |-> irq)
		else $error("enabled checksum flag did not raise irq");

	irq_quiet_a: assert property (
		(s_reg.mask == '0) |-> !irq)
		else $error("irq raised with every source masked");

	scan_length_a: assert property (
		scan_start |-> ##18 (scan_done || s_reg.lock_run < 5'd18))
		else $error("checksum pass did not finish in 18 cycles");

	sum_readonly_a: assert property (
		(do_write && s_reg.aw_idx == GUARD_IDX && locked && !scan_done) |=> $stable(s_reg.sum))
		else $error("write changed the checksum field");

	sum_period_a: assert property (
		scan_done |-> ##25 (scan_done || s_reg.lock_run < 5'd25))
		else $error("checksum not updated 25 cycles later");

	sum_spacing_a: assert property (
		scan_done |=> !scan_done [*8])
		else $error("checksum updated too soon");

	sum_update_a: assert property (
		(scan_done && locked) |=> s_reg.sum == $past(scan_sum))
		else $error("checksum field missed a finished pass");

	sum_cleared_a: assert property (
		!locked |=> s_reg.sum == SUM_RESET)
		else $error("checksum field not zero while open");

	sum_repeat_a: assert property (
		(scan_done && s_reg.sum_ok && locked) |-> scan_sum == s_reg.sum)
		else $error("two passes over a frozen map disagree");

	key_reset_a: assert property (
		$rose(rst_b) |-> (s_reg.key == KEY_OPEN && s_reg.sum == SUM_RESET))
		else $error("map not open with a clear checksum after reset");

	locked_hold_a: assert property (
		(do_write && locked && s_reg.aw_idx < 6'(MAP_WORDS)) |-> !map_wr.en)
		else $error("locked write reached the map store");

	pass_period_a: assert property (
		scan_start |-> ##25 (scan_start || !locked || s_reg.lock_run < 5'd25))
		else $error("checksum pass not restarted 25 cycles later");
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the map guard: AXI4-Lite access, key lock, checksum and interrupt.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench;
	import map_guard_pkg::*;

	logic clk, rst_b;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [23:0] mem [0:30];
	logic [31:0] rd;
	logic [15:0] sum;
	int fail_count = 0;
	int compares = 0;

	map_guard i_map_guard (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.irq(irq));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Handshakes are judged on ready levels seen mid-cycle, which hold up to the next edge.
	task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic [3:0] s,
			output logic [1:0] r);
		logic aw_now, w_now, b_now;
		int n;
		// One idle edge between calls, so no strobe is lowered and raised in one step.
		@(posedge clk);
		n = 0;
		b_now = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {8'h00, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b_now !== 1'b1) begin
			@(negedge clk);
			aw_now = awvalid && awready;
			w_now = wvalid && wready;
			b_now = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw_now) awvalid <= 1'b0;
			if (w_now) wvalid <= 1'b0;
			if (b_now) bready <= 1'b0;
			n++;
			if (n > 50) begin
				fail_count++;
				final_report();
			end
		end
	endtask

	task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_now, r_now;
		int n;
		@(posedge clk);
		n = 0;
		r_now = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r_now !== 1'b1) begin
			@(negedge clk);
			ar_now = arvalid && arready;
			r_now = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar_now) arvalid <= 1'b0;
			if (r_now) rready <= 1'b0;
			n++;
			if (n > 50) begin
				fail_count++;
				final_report();
			end
		end
	endtask

	task automatic chk_irq(input logic exp);
		@(negedge clk);
		`CHK(irq, exp)
		@(posedge clk);
	endtask

	// Reference CRC-16 over map words 0..30, each 24 bits sent MSB first.
	function automatic logic [15:0] crc_of();
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = 0; i < 31; i++) begin
			for (int b = 23; b >= 0; b--) begin
				fb = c[15] ^ mem[i][b];
				c = {c[14:0], 1'b0};
				if (fb) c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction

	// Locks with the given key, waits two checksum periods and checks the guard word.
	task automatic lock_check(input logic [7:0] key);
		wr(8'h7c, {key, 16'h0000}, 4'h4, resp);
		`CHK(resp, RESP_OKAY)
		repeat (2 * SUM_PERIOD) @(posedge clk);
		sum = crc_of();
		rdreg(8'h7c, rd, resp);
		`CHK(rd, {8'h00, key, sum})
		repeat (SUM_PERIOD) @(posedge clk);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, {8'h00, key, sum})
	endtask

	initial begin
		rst_b = 1'b0;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = '0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, 32'h00a50000)
		rdreg(8'h80, rd, resp);
		`CHK(rd, 32'h00000000)
		rdreg(8'h84, rd, resp);
		`CHK(rd, 32'h00000000)
		chk_irq(1'b0);
		rdreg(8'h00, rd, resp);
		`CHK(rd, 32'h00000000)
		$display("test reset done");

		for (int i = 0; i < 31; i++) begin
			mem[i] = {i[7:0], ~i[7:0], 8'h5a ^ i[7:0]};
			wr(8'(i * 4), mem[i], 4'h7, resp);
			`CHK(resp, RESP_OKAY)
		end
		for (int i = 0; i < 31; i++) begin
			rdreg(8'(i * 4), rd, resp);
			`CHK(rd, {8'h00, mem[i]})
		end
		wr(8'h7c, 24'ha5ffff, 4'h7, resp);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, 32'h00a50000)
		wr(8'h88, 24'h000001, 4'h7, resp);
		`CHK(resp, RESP_DECERR)
		rdreg(8'h88, rd, resp);
		`CHK(resp, RESP_DECERR)
		$display("test open map done");

		lock_check(8'h3c);
		wr(8'h7c, 24'h3cabcd, 4'h7, resp);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, {8'h00, 8'h3c, sum})
		for (int i = 0; i < 31; i++) begin
			rdreg(8'(i * 4), rd, resp);
			`CHK(rd, {8'h00, HIDDEN_VALUE})
			`CHK(resp, RESP_OKAY)
		end
		wr(8'h08, 24'h777777, 4'h7, resp);
		`CHK(resp, RESP_SLVERR)
		rdreg(8'h80, rd, resp);
		`CHK(rd, 32'h00000002)
		chk_irq(1'b0);
		wr(8'h84, 24'h000002, 4'h7, resp);
		chk_irq(1'b1);
		wr(8'h80, 24'h000002, 4'h7, resp);
		chk_irq(1'b0);
		wr(8'h84, 24'h000003, 4'h7, resp);
		$display("test locked map done");

		wr(8'h7c, 24'ha50000, 4'h4, resp);
		@(posedge clk);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, 32'h00a50000)
		rdreg(8'h80, rd, resp);
		`CHK(rd, 32'h00000000)
		chk_irq(1'b0);
		rdreg(8'h08, rd, resp);
		`CHK(rd, {8'h00, mem[2]})
		mem[2] = 24'h13579b;
		wr(8'h08, mem[2], 4'h7, resp);
		`CHK(resp, RESP_OKAY)
		repeat (2 * SUM_PERIOD) @(posedge clk);
		rdreg(8'h7c, rd, resp);
		`CHK(rd, 32'h00a50000)
		lock_check(8'h00);
		chk_irq(1'b0);
		$display("test relock done");
		final_report();
	end
endmodule

`default_nettype wire
